// File: src/test_key_control.v
// diagnostic key latch, diagnostic control bytes and console-file command control
// assumes data path supplies decoded word fields; file reader waits on file_ready
`include "test_key_defs.vh"

// Behaviour
// - commands 05 and 14 light diagnostic stop on S or M duplicate check
// - command 60 loads file data into C register, no execution
// - local-store load writes four file bytes at the address carried in the command byte
// - local-store word address comes from command bits 0-5
// - local-store execution inserts one idle cycle after each word
// - file pause records resume track/sector, halts reading until cleared
// - enabled diagnostic stop lights indicator and halts; start resumes
// - byte loads, Z stop, parity bit and local-store mode act only with key set; S/M dup and compare stops do not
// - branch word with OR and second field bit 0 sets key
// - branch word with A-minus function clears key
// - key-setting branch words still perform their normal branch actions
// - key state reads as bit 7 of external word at address 02
// - both diagnostic bytes load from the C register constant field
// - retry scratch at external 18 stays readable and writable
// - low byte bit 0 selects Z nonzero stop or preserve bad parity
// - command 70 loads C register from file data and executes it
// - command 7F compares M byte 3 bits after execute; mismatch stops file
// - nonzero Z stop halts clock, sets file stop latch, lights indicator
// - local-store mode fetches each word from local storage into C
module test_key_control (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    input wire clk_en,
    // console file
    input wire file_cmd_valid,
    input wire [7:0] file_cmd,
    input wire [31:0] file_data_holding_reg,
    input wire [7:0] file_pause_ts,
    output wire file_ready,
    output reg [7:0] resume_ts_q,
    output reg file_restart_q,
    output reg file_stop_q,
    // console pins (asynchronous)
    input wire start_button,
    input wire s_dup_check,
    input wire m_dup_check,
    // executing control word fields
    input wire word_valid,
    input wire [2:0] word_type,
    input wire [1:0] word_func,
    input wire [7:0] second_control_field,
    input wire [1:0] diag_op,
    input wire clear_file_pause,
    input wire [7:0] z_out,
    input wire [2:0] m_byte3_bits,
    input wire [2:0] m_byte3_expect,
    input wire local_store_exec_set,
    input wire local_store_exec_clear,
    // external register port
    input wire ext_wr,
    input wire ext_rd,
    input wire [7:0] ext_addr,
    input wire [31:0] ext_wdata,
    output reg [31:0] ext_rdata_q,
    // local storage
    input wire [31:0] ls_rdata,
    output reg [5:0] ls_addr_q,
    output reg [31:0] ls_wdata_q,
    output reg ls_we_q,
    // c register and cpu control
    output reg [31:0] c_reg_q,
    output reg exec_q,
    output reg idle_cycle_q,
    output reg cpu_halt_q,
    output reg test_stop_light_q,
    output reg test_key_q,
    output reg [7:0] test_control_low_q,
    output reg [7:0] test_control_high_q,
    output reg [31:0] retry_scratch_q,
    output wire preserve_bad_parity,
    output reg local_store_exec_mode_q
);

// ****************************************
// states
// ****************************************
localparam [3:0] ST_IDLE = 4'b0001;
localparam [3:0] ST_CMP = 4'b0010;
localparam [3:0] ST_LS_EXEC = 4'b0100;
localparam [3:0] ST_LS_IDLE = 4'b1000;

reg [3:0] state_q;
reg [3:0] state_d;
reg [2:0] start_sync_q;
reg [2:0] sdup_sync_q;
reg [2:0] mdup_sync_q;
reg start_stable_q;
reg sdup_stable_q;
reg mdup_stable_q;
reg start_prev_q;
reg stop_s_arm_q;
reg stop_m_arm_q;
reg pause_q;
reg cmp_pending_q;

wire [7:0] k_field = c_reg_q[7:0];
wire branch_word = word_valid && (word_type == `WORD_TYPE_BRANCH);
wire set_test_key = branch_word && (word_func == `FUNC_OR) && second_control_field[0];
wire clear_test_key = branch_word && (word_func == `FUNC_A_MINUS);
wire z_stop_en = test_key_q && test_control_low_q[`Z_STOP_BIT_POS];
wire z_stop = z_stop_en && word_valid && (z_out != 8'h00);
wire dup_stop = (stop_s_arm_q && sdup_stable_q) || (stop_m_arm_q && mdup_stable_q);
wire cmp_fail = cmp_pending_q && (m_byte3_bits != m_byte3_expect);
wire start_press = start_stable_q && !start_prev_q;
wire any_stop = z_stop || dup_stop || cmp_fail;
wire cmd_take = file_cmd_valid && file_ready;
wire ls_load_cmd = (file_cmd[7:6] == `CMD_LS_LOAD_HI);

// preserve bad parity shares bit 0; data path uses it only on transfers
assign preserve_bad_parity = z_stop_en;
// reader holds off while paused, stopped, halted, comparing or in local-store mode
// compare cycle must block intake, else a word slips past a failing compare
assign file_ready = (state_q == ST_IDLE) && !pause_q && !file_stop_q && !cpu_halt_q
    && !local_store_exec_mode_q && !cmp_pending_q;

// ****************************************
// pin synchronisers
// ****************************************
// stable copy only moves once second and third stages agree
always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        start_sync_q <= 3'h0;
        sdup_sync_q <= 3'h0;
        mdup_sync_q <= 3'h0;
        start_stable_q <= 1'b0;
        sdup_stable_q <= 1'b0;
        mdup_stable_q <= 1'b0;
        start_prev_q <= 1'b0;
    end else if (clk_en) begin
        start_sync_q <= {start_sync_q[1:0], start_button};
        sdup_sync_q <= {sdup_sync_q[1:0], s_dup_check};
        mdup_sync_q <= {mdup_sync_q[1:0], m_dup_check};
        if (start_sync_q[1] == start_sync_q[2]) begin
            start_stable_q <= start_sync_q[2];
        end
        if (sdup_sync_q[1] == sdup_sync_q[2]) begin
            sdup_stable_q <= sdup_sync_q[2];
        end
        if (mdup_sync_q[1] == mdup_sync_q[2]) begin
            mdup_stable_q <= mdup_sync_q[2];
        end
        start_prev_q <= start_stable_q;
    end
end

// ****************************************
// sequencer
// ****************************************
always @* begin
    state_d = state_q;
    case (state_q)
        ST_IDLE: begin
            if (local_store_exec_mode_q && !cpu_halt_q) begin
                state_d = ST_LS_EXEC;
            end else if (cmd_take && file_cmd == `CMD_LOAD_EXEC_CMP) begin
                state_d = ST_CMP;
            end
        end
        ST_CMP: begin
            state_d = ST_IDLE;
        end
        ST_LS_EXEC: begin
            state_d = ST_LS_IDLE;
        end
        ST_LS_IDLE: begin
            if (local_store_exec_mode_q && !cpu_halt_q) begin
                state_d = ST_LS_EXEC;
            end else begin
                state_d = ST_IDLE;
            end
        end
        default: begin
            state_d = ST_IDLE;
        end
    endcase
end

always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        state_q <= ST_IDLE;
        c_reg_q <= `RESET_WORD;
        exec_q <= 1'b0;
        idle_cycle_q <= 1'b0;
        ls_addr_q <= 6'h00;
        ls_wdata_q <= `RESET_WORD;
        ls_we_q <= 1'b0;
        cmp_pending_q <= 1'b0;
        stop_s_arm_q <= 1'b0;
        stop_m_arm_q <= 1'b0;
        pause_q <= 1'b0;
        resume_ts_q <= `RESET_TS;
        file_restart_q <= 1'b0;
        file_stop_q <= 1'b0;
    end else if (clk_en) begin
        state_q <= state_d;
        exec_q <= 1'b0;
        ls_we_q <= 1'b0;
        file_restart_q <= 1'b0;
        // dummy cycle trails the execute pulse, never overlaps it
        idle_cycle_q <= (state_q == ST_LS_IDLE);
        cmp_pending_q <= (state_q == ST_CMP);
        if (cmd_take) begin
            case (file_cmd)
                `CMD_STOP_S_DUP: begin
                    stop_s_arm_q <= 1'b1;
                end
                `CMD_STOP_M_DUP: begin
                    stop_m_arm_q <= 1'b1;
                end
                `CMD_LOAD_WORD: begin
                    c_reg_q <= file_data_holding_reg;
                end
                `CMD_LOAD_EXEC, `CMD_LOAD_EXEC_CMP: begin
                    c_reg_q <= file_data_holding_reg;
                    exec_q <= 1'b1;
                end
                `CMD_FILE_PAUSE: begin
                    resume_ts_q <= file_pause_ts;
                    pause_q <= 1'b1;
                end
                default: begin
                    if (ls_load_cmd) begin
                        // command byte picks the word address; data comes from the file holding register
                        ls_addr_q <= file_cmd[`CMD_LS_ADDR_HI:`CMD_LS_ADDR_LO];
                        ls_wdata_q <= file_data_holding_reg;
                        ls_we_q <= 1'b1;
                    end
                end
            endcase
        end
        if (state_q == ST_LS_EXEC) begin
            c_reg_q <= ls_rdata;
            exec_q <= 1'b1;
        end
        if (pause_q && clear_file_pause) begin
            pause_q <= 1'b0;
            file_restart_q <= 1'b1;
        end
        // any stop latches the reader off; start clears the latch
        if (any_stop) begin
            file_stop_q <= 1'b1;
        end else if (start_press) begin
            file_stop_q <= 1'b0;
        end
    end
end

// ****************************************
// diagnostic key, stop and mode
// ****************************************
always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        test_key_q <= 1'b0;
        cpu_halt_q <= 1'b0;
        test_stop_light_q <= 1'b0;
        local_store_exec_mode_q <= 1'b0;
    end else if (clk_en) begin
        // branch action itself runs on in the data path untouched
        if (set_test_key) begin
            test_key_q <= 1'b1;
        end else if (clear_test_key) begin
            test_key_q <= 1'b0;
        end
        // set wins over start in the same cycle
        if (any_stop) begin
            cpu_halt_q <= 1'b1;
            test_stop_light_q <= 1'b1;
        end else if (start_press) begin
            cpu_halt_q <= 1'b0;
        end
        // light stays on through a scope loop started by start
        if (local_store_exec_set && test_key_q) begin
            local_store_exec_mode_q <= 1'b1;
        end else if (local_store_exec_clear || !test_key_q) begin
            local_store_exec_mode_q <= 1'b0;
        end
    end
end

// ****************************************
// diagnostic bytes and external registers
// ****************************************
always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        test_control_low_q <= `RESET_BYTE;
        test_control_high_q <= `RESET_BYTE;
        retry_scratch_q <= `RESET_WORD;
        ext_rdata_q <= `RESET_WORD;
    end else if (clk_en) begin
        if (word_valid && test_key_q && diag_op == `OP_LOAD_TEST_LOW) begin
            test_control_low_q <= k_field;
        end
        if (word_valid && test_key_q && diag_op == `OP_LOAD_TEST_HIGH) begin
            test_control_high_q <= k_field;
        end
        if (ext_wr && ext_addr == `EXT_ADDR_RETRY_SCRATCH) begin
            retry_scratch_q <= ext_wdata;
        end
        if (ext_rd) begin
            case (ext_addr)
                `EXT_ADDR_TEST_CONTROL_HIGH: begin
                    ext_rdata_q <= {24'h000000, test_key_q, test_control_high_q[6:0]};
                end
                `EXT_ADDR_TEST_CONTROL_LOW: begin
                    ext_rdata_q <= {24'h000000, test_control_low_q};
                end
                `EXT_ADDR_RETRY_SCRATCH: begin
                    ext_rdata_q <= retry_scratch_q;
                end
                default: begin
                    ext_rdata_q <= `RESET_WORD;
                end
            endcase
        end
    end
end

endmodule // test_key_control

// File: inc/test_key_defs.vh
// constants for the diagnostic key and console-file command control block
// assumes inclusion by the single design file only
`ifndef TEST_KEY_DEFS_VH
`define TEST_KEY_DEFS_VH
// ****************************************
// external addresses
// ****************************************
`define EXT_ADDR_TEST_CONTROL_HIGH 8'h02
`define EXT_ADDR_RETRY_SCRATCH 8'h18
`define EXT_ADDR_TEST_CONTROL_LOW 8'h01
// ****************************************
// field positions
// ****************************************
`define KEY_BIT_POS 7
`define Z_STOP_BIT_POS 0
`define CMD_LS_ADDR_HI 5
`define CMD_LS_ADDR_LO 0
// ****************************************
// console-file commands
// ****************************************
`define CMD_STOP_S_DUP 8'h05
`define CMD_STOP_M_DUP 8'h14
`define CMD_LOAD_WORD 8'h60
`define CMD_LOAD_EXEC 8'h70
`define CMD_LOAD_EXEC_CMP 8'h7F
`define CMD_LS_LOAD_HI 2'h3
`define CMD_FILE_PAUSE 8'h41
// ****************************************
// word decode and functions
// ****************************************
`define WORD_TYPE_BRANCH 3'h1
`define FUNC_OR 2'h1
`define FUNC_A_MINUS 2'h2
`define OP_LOAD_TEST_LOW 2'h1
`define OP_LOAD_TEST_HIGH 2'h2
// ****************************************
// reset values
// ****************************************
`define RESET_BYTE 8'h00
`define RESET_WORD 32'h00000000
`define RESET_TS 8'h00
`endif

// File: tb/key_monitor.sv
// concurrent checks on the diagnostic key and console-file control ports
// assumes binding onto test_key_control with matching port names
module key_monitor (
    // clock and reset
    input wire core_clk,
    input wire rstn,
    // inputs
    input wire clk_en,
    input wire file_cmd_valid,
    input wire [7:0] file_cmd,
    input wire [31:0] file_data_holding_reg,
    input wire [7:0] file_pause_ts,
    input wire word_valid,
    input wire [2:0] word_type,
    input wire [1:0] word_func,
    input wire [7:0] second_control_field,
    input wire [7:0] z_out,
    // outputs
    input wire file_ready,
    input wire [7:0] resume_ts_q,
    input wire [31:0] c_reg_q,
    input wire exec_q,
    input wire [5:0] ls_addr_q,
    input wire [31:0] ls_wdata_q,
    input wire ls_we_q,
    input wire idle_cycle_q,
    input wire cpu_halt_q,
    input wire file_stop_q,
    input wire test_stop_light_q,
    input wire test_key_q,
    input wire [7:0] test_control_low_q,
    input wire preserve_bad_parity,
    input wire local_store_exec_mode_q
);
    timeunit 1ns;
    timeprecision 1ps;
    wire take = clk_en & file_cmd_valid & file_ready;
    wire brw = clk_en & word_valid & (word_type == 3'h1);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ****************************************
    // properties
    // ****************************************
    chk_load_word: assert property (
        take && file_cmd == 8'h60 |=> c_reg_q == $past(file_data_holding_reg) && !exec_q)
        else $error("load word wrong");
    chk_load_exec: assert property (
        take && file_cmd == 8'h70 |=> c_reg_q == $past(file_data_holding_reg) && exec_q)
        else $error("load execute wrong");
    chk_ls_load: assert property (
        take && file_cmd[7:6] == 2'h3 |=> ls_we_q && ls_addr_q == $past(file_cmd[5:0])
        && ls_wdata_q == $past(file_data_holding_reg)) else $error("ls load wrong");
    chk_key_set: assert property (
        brw && word_func == 2'h1 && second_control_field[0] |=> test_key_q)
        else $error("key not set");
    chk_key_clear: assert property (
        brw && word_func == 2'h2 |=> !test_key_q) else $error("key not cleared");
    chk_parity_gate: assert property (
        preserve_bad_parity == (test_key_q && test_control_low_q[0]))
        else $error("parity gate wrong");
    chk_pause_rec: assert property (
        take && file_cmd == 8'h41 |=> resume_ts_q == $past(file_pause_ts) && !file_ready)
        else $error("pause not recorded");
    chk_idle_after: assert property (
        exec_q && local_store_exec_mode_q |=> idle_cycle_q && !exec_q)
        else $error("no idle cycle");
    chk_z_stop: assert property (
        clk_en && word_valid && test_key_q && test_control_low_q[0] && z_out != 8'h00
        |-> ##[1:3] (cpu_halt_q && file_stop_q && test_stop_light_q))
        else $error("z stop missing");
    chk_cmp_busy: assert property (
        take && file_cmd == 8'h7F |=> !file_ready ##1 !file_ready)
        else $error("compare not busy");
    cover property (take && file_cmd == 8'h7F);
    cover property ($rose(cpu_halt_q));
    cover property (idle_cycle_q);
endmodule // key_monitor

bind test_key_control key_monitor u_key_monitor (.*);

// File: tb/file_reader_model.sv
// console-file reader: offers one command and data word at a time
// assumes file_ready is settled by the falling edge
module file_reader_model (
    // clock
    input wire core_clk,
    // handshake
    input wire file_ready,
    output logic file_cmd_valid = 1'b0,
    output logic [7:0] file_cmd = 8'h00,
    output logic [31:0] file_data_holding_reg = 32'h00000000,
    output logic [7:0] file_pause_ts = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // offer held until a rising edge sees ready; gives up after 16 cycles
    task send(input logic [7:0] c, input logic [31:0] d, input logic [7:0] ts, output logic ok);
        int i;
        ok = 1'b0;
        @(posedge core_clk);
        file_cmd_valid <= 1'b1;
        file_cmd <= c;
        file_data_holding_reg <= d;
        file_pause_ts <= ts;
        for (i = 0; i < 16 && !ok; i++) begin
            @(negedge core_clk);
            if (file_ready === 1'b1) ok = 1'b1;
            @(posedge core_clk);
        end
        // released lines show inverted data, not the stale word
        file_cmd_valid <= 1'b0;
        file_cmd <= ~c;
        file_data_holding_reg <= ~d;
        file_pause_ts <= ~ts;
    endtask
endmodule // file_reader_model

// File: tb/test_key_control_tb.sv
// self-checking bench for the diagnostic key and console-file control
// assumes the reader model drives the file side; clk_en high except one freeze check
module test_key_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, start_button = 1'b0;
    logic s_dup_check = 1'b0, m_dup_check = 1'b0, word_valid = 1'b0, clear_file_pause = 1'b0;
    logic local_store_exec_set = 1'b0, local_store_exec_clear = 1'b0, ext_wr = 1'b0;
    logic ext_rd = 1'b0, ok;
    logic [2:0] word_type = 3'h0, m_byte3_bits = 3'h0, m_byte3_expect = 3'h0;
    logic [1:0] word_func = 2'h0, diag_op = 2'h0;
    logic [7:0] second_control_field = 8'h00, z_out = 8'h00, ext_addr = 8'h00;
    logic [31:0] ext_wdata = 32'h00000000, ls_rdata = 32'h00000000;
    wire file_cmd_valid, file_ready, file_restart_q, file_stop_q, ls_we_q, exec_q, idle_cycle_q;
    wire cpu_halt_q, test_stop_light_q, test_key_q, preserve_bad_parity;
    wire local_store_exec_mode_q;
    wire [7:0] file_cmd, file_pause_ts, resume_ts_q, test_control_low_q, test_control_high_q;
    wire [31:0] file_data_holding_reg, ext_rdata_q, ls_wdata_q, c_reg_q, retry_scratch_q;
    wire [5:0] ls_addr_q;
    int n_mismatch = 0, check_count = 0, i;
    always #2.5 core_clk = ~core_clk;
    test_key_control u_test_key_control (.*);
    file_reader_model u_file_reader_model (.*);
    // ****************************************
    // helpers
    // ****************************************
    task summarize;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic good, input string msg);
        check_count++;
        if (good !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task bound;
        if (i >= 8) begin
            chk(1'b0, "wait ran out");
            summarize;
        end
    endtask
    task do_reset;
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
    endtask
    task send(input logic [7:0] c, input logic [31:0] d);
        u_file_reader_model.send(c, d, 8'h46, ok);
        #1;
        if (ok !== 1'b1) begin
            chk(1'b0, "file offer refused");
            summarize;
        end
    endtask
    task word(input logic [2:0] t, input logic [1:0] f, input logic [7:0] c2, input logic [1:0] op);
        @(posedge core_clk);
        word_valid <= 1'b1;
        word_type <= t;
        word_func <= f;
        second_control_field <= c2;
        diag_op <= op;
        @(posedge core_clk);
        word_valid <= 1'b0;
        #1;
    endtask
    task ext(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        ext_wr <= wr;
        ext_rd <= !wr;
        ext_addr <= a;
        ext_wdata <= d;
        @(posedge core_clk);
        ext_wr <= 1'b0;
        ext_rd <= 1'b0;
        #1;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_words;
        chk(c_reg_q === 32'h0 && test_key_q === 1'b0 && file_ready === 1'b1, "reset values");
        send(8'h60, 32'hA5A50081);
        chk(c_reg_q === 32'hA5A50081 && exec_q === 1'b0, "load word");
        send(8'h70, 32'h20901000);
        chk(c_reg_q === 32'h20901000 && exec_q === 1'b1, "load exec");
        send(8'hC5, 32'h00000FFF);
        chk(ls_we_q === 1'b1 && ls_addr_q === 6'h05 && ls_wdata_q === 32'hFFF, "ls");
        send(8'hFF, 32'h0000ABCD);
        chk(ls_addr_q === 6'h3F && ls_wdata_q === 32'h0000ABCD, "ls top word");
    endtask
    task t_key;
        send(8'h60, 32'h00000081);
        word(3'h0, 2'h0, 8'h00, 2'h1);
        chk(test_control_low_q === 8'h00, "load without key");
        word(3'h1, 2'h1, 8'hFE, 2'h0);
        chk(test_key_q === 1'b0, "key set by even field");
        word(3'h1, 2'h1, 8'h01, 2'h0);
        chk(test_key_q === 1'b1, "key set");
        word(3'h0, 2'h0, 8'h00, 2'h1);
        chk(test_control_low_q === 8'h81 && preserve_bad_parity === 1'b1, "low");
        word(3'h0, 2'h0, 8'h00, 2'h2);
        chk(test_control_high_q === 8'h81, "high byte");
        ext(1'b0, 8'h02, 32'h0);
        chk(ext_rdata_q === 32'h00000081, "key readback");
        word(3'h1, 2'h2, 8'h01, 2'h0);
        chk(test_key_q === 1'b0 && preserve_bad_parity === 1'b0, "key clear");
        ext(1'b0, 8'h02, 32'h0);
        chk(ext_rdata_q === 32'h00000001, "key off readback");
        ext(1'b0, 8'h01, 32'h0);
        chk(ext_rdata_q === 32'h00000081, "low readback");
        ext(1'b1, 8'h18, 32'hDEADBEEF);
        ext(1'b0, 8'h18, 32'h0);
        chk(ext_rdata_q === 32'hDEADBEEF && retry_scratch_q === 32'hDEADBEEF, "scratch");
        ext(1'b0, 8'h33, 32'h0);
        chk(ext_rdata_q === 32'h0, "unmapped read");
    endtask
    task t_pause;
        send(8'h41, 32'h0);
        chk(resume_ts_q === 8'h46 && file_ready === 1'b0, "pause");
        @(posedge core_clk);
        clear_file_pause <= 1'b1;
        @(posedge core_clk);
        clear_file_pause <= 1'b0;
        for (i = 0; i < 8 && file_restart_q !== 1'b1; i++) @(posedge core_clk);
        bound;
        #1;
        chk(resume_ts_q === 8'h46 && file_ready === 1'b1, "restart point");
    endtask
    task t_zstop;
        do_reset;
        word(3'h1, 2'h1, 8'h01, 2'h0);
        send(8'h60, 32'h00000001);
        word(3'h0, 2'h0, 8'h00, 2'h1);
        z_out <= 8'h02;
        word(3'h0, 2'h0, 8'h00, 2'h0);
        for (i = 0; i < 8 && cpu_halt_q !== 1'b1; i++) @(posedge core_clk);
        bound;
        #1;
        chk(file_stop_q === 1'b1 && test_stop_light_q === 1'b1, "z stop");
        @(posedge core_clk);
        z_out <= 8'h00;
        start_button <= 1'b1;
        for (i = 0; i < 8 && cpu_halt_q !== 1'b0; i++) @(posedge core_clk);
        bound;
        start_button <= 1'b0;
        #1;
        chk(test_stop_light_q === 1'b1, "start resumes");
    endtask
    task t_stops;
        for (int k = 0; k < 2; k++) begin
            do_reset;
            send(k ? 8'h14 : 8'h05, 32'h0);
            s_dup_check <= (k == 0);
            m_dup_check <= (k == 1);
            for (i = 0; i < 8 && test_stop_light_q !== 1'b1; i++) @(posedge core_clk);
            bound;
            s_dup_check <= 1'b0;
            m_dup_check <= 1'b0;
        end
        do_reset;
        send(8'h7F, 32'h0);
        repeat (4) @(posedge core_clk);
        #1;
        chk(file_stop_q === 1'b0 && file_ready === 1'b1, "compare match");
        m_byte3_bits <= 3'h5;
        send(8'h7F, 32'h0);
        for (i = 0; i < 8 && file_stop_q !== 1'b1; i++) @(posedge core_clk);
        bound;
        #1;
        chk(test_stop_light_q === 1'b1 && file_ready === 1'b0, "compare miss");
    endtask
    task t_lsexec;
        do_reset;
        m_byte3_bits <= 3'h0;
        ls_rdata <= 32'h12345678;
        word(3'h1, 2'h1, 8'h01, 2'h0);
        local_store_exec_set <= 1'b1;
        @(posedge core_clk);
        local_store_exec_set <= 1'b0;
        for (i = 0; i < 8 && exec_q !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        bound;
        chk(c_reg_q === 32'h12345678 && file_ready === 1'b0, "ls fetch");
        chk(local_store_exec_mode_q === 1'b1, "ls mode on");
        @(posedge core_clk);
        #1;
        chk(idle_cycle_q === 1'b1 && exec_q === 1'b0, "idle cycle");
        clk_en <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(idle_cycle_q === 1'b1 && exec_q === 1'b0, "frozen by clk_en");
        clk_en <= 1'b1;
        @(posedge core_clk);
        local_store_exec_clear <= 1'b1;
        @(posedge core_clk);
        local_store_exec_clear <= 1'b0;
    endtask
    initial begin
        do_reset;
        t_words;
        t_key;
        t_pause;
        t_zstop;
        t_stops;
        t_lsexec;
        summarize;
    end
endmodule // test_key_control_tb
